// ### pkg/nvac_defs.vh
// Constants for the non-volatile data memory access controller
`ifndef NVAC_DEFS_VH
`define NVAC_DEFS_VH
// Register byte offsets on the AXI4-Lite slave
`define NVAC_ADDR_OFS 8'h00
`define NVAC_DATA_OFS 8'h04
`define NVAC_BANK_OFS 8'h08
`define NVAC_PTR_OFS 8'h0C
`define NVAC_IND_OFS 8'h10
`define NVAC_INTC_OFS 8'h14
// Control register location in bank one
`define NVAC_CTRL_LOC 8'h40
`define NVAC_BANK_ONE 8'h01
// Control register bit positions
`define NVAC_RD_BIT 0
`define NVAC_READ_ENABLE_BIT_BIT 1
`define NVAC_WT_BIT 2
`define NVAC_WRITE_ENABLE_BIT_BIT 3
// Interrupt enable bit in interrupt control register one
`define NVAC_IE_BIT 1
// Internal operation times in ns and clock period
`define NVAC_CLK_NS 40
`define NVAC_READ_NS 200
`define NVAC_WRITE_NS 2000
// AXI responses
`define NVAC_RESP_OKAY 2'b00
`define NVAC_RESP_SLVERR 2'b10
`endif

// ### verilog/nvac_mem.v
// Sixty-four by eight storage array with registered read data
`timescale 1ns/10ps
module nvac_mem #(
  parameter AW = 6,
  parameter DW = 8
) (
  input wire aclk,
  input wire we,
  input wire re,
  input wire [AW-1:0] addr,
  input wire [DW-1:0] wdata,
  output reg [DW-1:0] rdata
);
  // Storage cells
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // Write on request, registered read
  always @(posedge aclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    if (re) begin
      rdata <= mem[addr];
    end
  end
endmodule

// ### verilog/nvac_top.v
// AXI4-Lite controller giving byte access to the non-volatile data memory
`timescale 1ns/10ps
`include "nvac_defs.vh"
module nvac_top #(
  parameter AW = 6,
  parameter READ_NS = `NVAC_READ_NS,
  parameter WRITE_NS = `NVAC_WRITE_NS
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output wire nvm_write_done_irq
);
  // Cycle counts, rounded up, at least one
  localparam integer RD_CYC_RAW = (READ_NS + `NVAC_CLK_NS - 1) / `NVAC_CLK_NS;
  localparam integer WR_CYC_RAW = (WRITE_NS + `NVAC_CLK_NS - 1) / `NVAC_CLK_NS;
  localparam integer RD_CYC = (RD_CYC_RAW < 1) ? 1 : RD_CYC_RAW;
  localparam integer WR_CYC = (WR_CYC_RAW < 1) ? 1 : WR_CYC_RAW;
  localparam [15:0] RD_CNT = RD_CYC[15:0];
  localparam [15:0] WR_CNT = WR_CYC[15:0];

  // Operation states, one-hot
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_READ = 3'b010;
  localparam [2:0] ST_WRITE = 3'b100;

  // Software-visible registers
  reg [AW-1:0] nvm_address_reg_q;   // Location select
  reg [7:0] nvm_data_reg_q;         // Byte in or out
  reg [7:0] bank_select_q;          // Data memory bank
  reg [7:0] memory_pointer_one_q;   // Indirect pointer
  reg read_start_bit_q;             // Read in progress
  reg read_enable_bit_q;            // Reads allowed
  reg write_start_bit_q;            // Write in progress
  reg write_enable_bit_q;           // Writes allowed
  reg [7:0] interrupt_control_reg_one_q; // Holds interrupt enable
  reg write_done_q;                 // Sticky write completion
  // Engine state
  reg [2:0] state_q;
  reg [15:0] cnt_q;
  reg rd_fetch_q;                   // Read data returns next cycle
  // Bus channel state
  reg aw_held_q;
  reg [7:0] aw_addr_q;
  reg w_held_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;

  // Memory interface
  wire mem_we;
  wire mem_re;
  wire [7:0] mem_rdata;

  // Word-aligned offset test
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a[7:2] == ofs[7:2]);
    end
  endfunction

  // Pack control bits into a byte
  function [7:0] ctrl_byte;
    input rd;
    input read_enable_bit;
    input wt;
    input write_enable_bit;
    begin
      ctrl_byte = 8'h00;
      ctrl_byte[`NVAC_RD_BIT] = rd;
      ctrl_byte[`NVAC_READ_ENABLE_BIT_BIT] = read_enable_bit;
      ctrl_byte[`NVAC_WT_BIT] = wt;
      ctrl_byte[`NVAC_WRITE_ENABLE_BIT_BIT] = write_enable_bit;
    end
  endfunction

  // Indirect window points at control register in bank one
  wire ind_ctrl = (bank_select_q == `NVAC_BANK_ONE) &&
                  (memory_pointer_one_q == `NVAC_CTRL_LOC);

  // Write channel handshakes: take each while not held and no response waits
  assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_q & ~s_axi_bvalid;
  wire aw_now = aw_held_q | s_axi_awvalid;
  wire w_now = w_held_q | s_axi_wvalid;
  wire [7:0] wa = aw_held_q ? aw_addr_q : s_axi_awaddr;
  wire [31:0] wd = w_held_q ? w_data_q : s_axi_wdata;
  wire [3:0] ws = w_held_q ? w_strb_q : s_axi_wstrb;
  wire do_wr = aw_now & w_now & ~s_axi_bvalid;
  wire wr_ok = hit(wa, `NVAC_ADDR_OFS) | hit(wa, `NVAC_DATA_OFS) |
               hit(wa, `NVAC_BANK_OFS) | hit(wa, `NVAC_PTR_OFS) |
               hit(wa, `NVAC_IND_OFS) | hit(wa, `NVAC_INTC_OFS);
  wire lane0 = ws[0];

  // Control write through indirect window
  wire ctrl_wr = do_wr & lane0 & hit(wa, `NVAC_IND_OFS) & ind_ctrl;
  wire [7:0] cw = wd[7:0];
  // Busy until fetched byte has landed; blocks starts and data changes
  wire busy = (state_q != ST_IDLE) | rd_fetch_q;
  // Start requests honoured only with enable already set, engine idle
  wire rd_go = ctrl_wr & cw[`NVAC_RD_BIT] & read_enable_bit_q &
               ~busy;
  wire wr_go = ctrl_wr & cw[`NVAC_WT_BIT] & write_enable_bit_q &
               ~read_enable_bit_q & ~cw[`NVAC_READ_ENABLE_BIT_BIT] &
               ~busy;

  // Read channel: accept when no answer pending
  assign s_axi_arready = ~s_axi_rvalid;

  // Engine end strobes
  wire cnt_end = (cnt_q == 16'h0001);
  wire rd_end = (state_q == ST_READ) & cnt_end;
  wire wr_end = (state_q == ST_WRITE) & cnt_end;

  assign mem_re = rd_end;
  assign mem_we = wr_end;

  // Storage array
  nvac_mem #(
    .AW(AW),
    .DW(8)
  ) nvac_mem_inst (
    .aclk(aclk),
    .we(mem_we),
    .re(mem_re),
    .addr(nvm_address_reg_q),
    .wdata(nvm_data_reg_q),
    .rdata(mem_rdata)
  );

  // Write channel capture and response
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_held_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `NVAC_RESP_OKAY;
    end else begin
      // Hold address taken alone
      if (s_axi_awvalid & s_axi_awready & ~do_wr) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      // Hold data taken alone
      if (s_axi_wvalid & s_axi_wready & ~do_wr) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      // Both present: answer
      if (do_wr) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `NVAC_RESP_OKAY : `NVAC_RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register file and engine
  always @(posedge aclk) begin
    if (!aresetn) begin
      nvm_address_reg_q <= {AW{1'b0}};
      nvm_data_reg_q <= 8'h00;
      bank_select_q <= 8'h00;
      memory_pointer_one_q <= 8'h00;
      read_start_bit_q <= 1'b0;
      read_enable_bit_q <= 1'b0;
      write_start_bit_q <= 1'b0;
      write_enable_bit_q <= 1'b0;
      interrupt_control_reg_one_q <= 8'h00;
      write_done_q <= 1'b0;
      state_q <= ST_IDLE;
      cnt_q <= 16'h0000;
      rd_fetch_q <= 1'b0;
    end else begin
      rd_fetch_q <= rd_end;
      // Plain registers, byte lane zero only
      if (do_wr & lane0) begin
        if (hit(wa, `NVAC_ADDR_OFS) & ~busy) begin
          nvm_address_reg_q <= wd[AW-1:0];
        end
        if (hit(wa, `NVAC_DATA_OFS) & ~busy) begin
          nvm_data_reg_q <= wd[7:0];
        end
        if (hit(wa, `NVAC_BANK_OFS)) begin
          bank_select_q <= wd[7:0];
        end
        if (hit(wa, `NVAC_PTR_OFS)) begin
          memory_pointer_one_q <= wd[7:0];
        end
        if (hit(wa, `NVAC_INTC_OFS)) begin
          interrupt_control_reg_one_q <= wd[7:0];
        end
      end
      // Enable bits follow control writes
      if (ctrl_wr) begin
        read_enable_bit_q <= cw[`NVAC_READ_ENABLE_BIT_BIT];
        write_enable_bit_q <= cw[`NVAC_WRITE_ENABLE_BIT_BIT];
      end
      // Fetched byte lands in data register
      if (rd_fetch_q) begin
        nvm_data_reg_q <= mem_rdata;
      end
      // Sticky completion: set beats clear
      if (wr_end) begin
        write_done_q <= 1'b1;
      end else if (ctrl_wr & cw[`NVAC_WT_BIT]) begin
        write_done_q <= 1'b0;
      end
      // Operation sequencer
      case (state_q)
        ST_IDLE: begin
          if (rd_go) begin
            state_q <= ST_READ;
            cnt_q <= RD_CNT;
            read_start_bit_q <= 1'b1;
          end else if (wr_go) begin
            state_q <= ST_WRITE;
            cnt_q <= WR_CNT;
            write_start_bit_q <= 1'b1;
          end
        end
        ST_READ: begin
          if (cnt_end) begin
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        ST_WRITE: begin
          if (cnt_end) begin
            state_q <= ST_IDLE;
            write_start_bit_q <= 1'b0;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
      // Read start drops once data is in place
      if (rd_fetch_q) begin
        read_start_bit_q <= 1'b0;
      end
    end
  end

  // Read data mux
  reg [31:0] rd_word;
  reg rd_ok;
  always @* begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    if (hit(s_axi_araddr, `NVAC_ADDR_OFS)) begin
      rd_word[AW-1:0] = nvm_address_reg_q;
    end else if (hit(s_axi_araddr, `NVAC_DATA_OFS)) begin
      rd_word[7:0] = nvm_data_reg_q;
    end else if (hit(s_axi_araddr, `NVAC_BANK_OFS)) begin
      rd_word[7:0] = bank_select_q;
    end else if (hit(s_axi_araddr, `NVAC_PTR_OFS)) begin
      rd_word[7:0] = memory_pointer_one_q;
    end else if (hit(s_axi_araddr, `NVAC_IND_OFS)) begin
      // Only the selected window shows control bits
      if (ind_ctrl) begin
        rd_word[7:0] = ctrl_byte(read_start_bit_q, read_enable_bit_q,
                                 write_start_bit_q, write_enable_bit_q);
      end
    end else if (hit(s_axi_araddr, `NVAC_INTC_OFS)) begin
      rd_word[7:0] = interrupt_control_reg_one_q;
    end else begin
      rd_ok = 1'b0;
    end
  end

  // Read channel answer
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `NVAC_RESP_OKAY;
    end else begin
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? `NVAC_RESP_OKAY : `NVAC_RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Completion interrupt gated by enable
  assign nvm_write_done_irq = write_done_q &
                              interrupt_control_reg_one_q[`NVAC_IE_BIT];
endmodule

// ### tb/nvac_top_monitor.sv
// Concurrent checks on the controller's bus ports and interrupt line
`timescale 1ns/10ps
`include "nvac_defs.vh"
module nvac_top_monitor (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [7:0] s_axi_araddr,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire nvm_write_done_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Read answer one cycle after the address is taken
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  // Read answer never rises without a request behind it
  a_read_cause: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
    else $error("read answer without request");
  // One write response per write
  a_write_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  // No new write taken while a response waits
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  // Only one byte of each word carries data
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  // Offsets past the map answer with an error
  a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h17
    |=> s_axi_rresp == `NVAC_RESP_SLVERR)
    else $error("unmapped read not refused");
  // Mapped aligned offsets answer okay
  a_mapped_ok: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr <= 8'h14
    && s_axi_araddr[1:0] == 2'h0 |=> s_axi_rresp == `NVAC_RESP_OKAY)
    else $error("mapped read refused");
  // Interrupt only drops through a register write
  a_irq_clear: assert property ($fell(nvm_write_done_irq) |-> $rose(s_axi_bvalid))
    else $error("interrupt dropped on its own");
  c_irq: cover property ($rose(nvm_write_done_irq));
  c_err: cover property (s_axi_rvalid && s_axi_rresp == `NVAC_RESP_SLVERR);
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind nvac_top nvac_top_monitor nvac_top_monitor_inst (.*);

// ### tb/nvac_sw_model.sv
// Bus master standing in for the core software
`timescale 1ns/10ps
module nvac_sw_model (
  input wire aclk,
  output logic [7:0] awaddr = 8'h00,
  output logic awvalid = 1'b0,
  input wire awready,
  output logic [31:0] wdata = 32'h0000_0000,
  output logic wvalid = 1'b0,
  input wire wready,
  input wire [1:0] bresp,
  input wire bvalid,
  output logic bready = 1'b0,
  output logic [7:0] araddr = 8'h00,
  output logic arvalid = 1'b0,
  input wire arready,
  input wire [31:0] rdata,
  input wire [1:0] rresp,
  input wire rvalid,
  output logic rready = 1'b0,
  output logic hung = 1'b0
);
  // One write: address and data offered together, ready sampled before the edge
  task wr(input [7:0] a, input [31:0] d, output [1:0] r);
    int n;
    bit ha, hw, hb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    hb = 1'b0;
    for (n = 0; n < 60 && !hb; n++) begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid;
      r = bresp;
      @(posedge aclk);
      // Released lines show the inverse, not the old value
      if (ha) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (hw) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end
    bready <= 1'b0;
    if (!hb) hung <= 1'b1;
  endtask
  // One read, data taken at the falling edge while the answer is valid
  task rd(input [7:0] a, output [31:0] d, output [1:0] r);
    int n;
    bit hr, hd;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    hd = 1'b0;
    for (n = 0; n < 60 && !hd; n++) begin
      @(negedge aclk);
      hr = arvalid && arready;
      hd = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (hr) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
    end
    rready <= 1'b0;
    if (!hd) hung <= 1'b1;
  endtask
endmodule

// ### tb/eeprom_data_access_controller_bench.sv
// Self-checking bench for the non-volatile memory access controller
`timescale 1ns/10ps
`include "nvac_defs.vh"
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module eeprom_data_access_controller_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr, araddr, o;
  logic [31:0] wdata, rdata, v;
  logic [1:0] bresp, rresp, r;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq, hung;
  logic stuck = 1'b0;
  int err_total = 0;
  int tests_run = 0;
  initial forever #20 aclk = ~aclk;
  // Write time shrunk and read time lengthened, both to 400 ns, so polling sees the busy phase
  nvac_top #(.READ_NS(400), .WRITE_NS(400)) nvac_top_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .nvm_write_done_irq(irq));
  nvac_sw_model nvac_sw_model_inst (.*);
  // Register access helpers
  task w(input [7:0] a, input [7:0] d);
    nvac_sw_model_inst.wr(a, {24'h0, d}, r);
  endtask
  task rc(input [7:0] a, input [7:0] e, input string n);
    nvac_sw_model_inst.rd(a, v, r);
    `CHK(n, {24'h0, e}, v)
  endtask
  // Poll a control bit until it reads low, bounded
  task poll(input int b);
    int n;
    for (n = 0; n < 50; n++) begin
      nvac_sw_model_inst.rd(8'h10, v, r);
      if (v[b] === 1'b0) break;
    end
    `CHK("poll", 1'b0, v[b])
    // Exhausted poll ends the run
    if (v[b] !== 1'b0) stuck <= 1'b1;
  endtask
  task t_reset;
    for (o = 8'h00; o < 8'h18; o += 8'h04) rc(o, 8'h00, "reset");
    `CHK("irq", 1'b0, irq)
  endtask
  // Control reachable only at bank one, pointer 40h
  task t_gate;
    w(8'h10, 8'h02);
    w(8'h08, 8'h01);
    w(8'h0C, 8'h41);
    w(8'h10, 8'h02);
    w(8'h0C, 8'h40);
    rc(8'h10, 8'h00, "ctrl gate");
    w(8'h10, 8'h02);
    rc(8'h10, 8'h02, "ctrl read_enable_bit");
    w(8'h10, 8'h0E);
    rc(8'h10, 8'h0A, "wt with read_enable_bit");
    w(8'h10, 8'h0E);
    rc(8'h10, 8'h0A, "wt read_enable_bit set");
    w(8'h10, 8'h00);
    w(8'h10, 8'h01);
    rc(8'h10, 8'h00, "rd no enable");
    w(8'h10, 8'h0C);
    rc(8'h10, 8'h08, "wt same word");
  endtask
  task t_write;
    w(8'h00, 8'hFF);
    rc(8'h00, 8'h3F, "addr width");
    w(8'h04, 8'hA5);
    w(8'h14, 8'h02);
    w(8'h10, 8'h08);
    w(8'h10, 8'h0C);
    rc(8'h10, 8'h0C, "wt busy");
    poll(2);
    `CHK("irq set", 1'b1, irq)
    w(8'h14, 8'h00);
    `CHK("irq masked", 1'b0, irq)
  endtask
  task t_read;
    w(8'h10, 8'h00);
    w(8'h04, 8'h00);
    w(8'h10, 8'h02);
    w(8'h10, 8'h03);
    rc(8'h10, 8'h03, "rd busy");
    poll(0);
    rc(8'h04, 8'hA5, "read data");
  endtask
  task t_unmapped;
    nvac_sw_model_inst.rd(8'h18, v, r);
    `CHK("rresp", `NVAC_RESP_SLVERR, r)
    nvac_sw_model_inst.wr(8'h1C, 32'h0000_0001, r);
    `CHK("bresp", `NVAC_RESP_SLVERR, r)
  endtask
  task tally_and_finish;
    $display("mismatches %0d of %0d checks", err_total, tests_run);
    if (err_total == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_gate;
    t_write;
    t_read;
    t_unmapped;
    tally_and_finish;
  end
  // A stuck bus wait or poll ends the run
  always @(posedge hung or posedge stuck) begin
    err_total++;
    tally_and_finish;
  end
endmodule
